/* File: hdl/gsr_pkg.sv */
/*
 Shared constants and carrier types for the gauge status readout block.
 Assumes a single 100 MHz clock domain and a synchronous active-high reset.
*/
package gsr_pkg;

    // Status select field codes, bits 3:0 map to command bits 11:8
    localparam logic [3:0] GSR_SEL_DEVICE = 4'h0;
    localparam logic [3:0] GSR_SEL_ACCUM = 4'h8;
    localparam logic [3:0] GSR_SEL_POS0 = 4'hc;
    localparam int GSR_SEL_TOP = 3;
    localparam int GSR_SEL_NEXT = 2;
    localparam int GSR_SEL_LOW = 1;
    localparam int GSR_SEL_BIT0 = 0;

    // Word geometry
    localparam int GSR_WORD_W = 16;
    localparam int GSR_ACC_W = 15;
    localparam int GSR_POS_W = 12;
    localparam int GSR_FRAME_W = 16;
    localparam logic [14:0] GSR_ACC_RESET = 15'h0000;
    localparam logic [11:0] GSR_POS_RESET = 12'h000;

    // Field positions of the command word carried on the shift input
    localparam int GSR_CMD_SEL_HI = 11;
    localparam int GSR_CMD_SEL_LO = 8;

    // Per-gauge live state from the motion logic
    typedef struct packed {
        logic heading;
        logic zeroEnd;
        logic offTarget;
        logic headingVsTarget;
        logic enabled;
        logic homingReq;
        logic homingOff;
        logic zeroFound;
        logic overTemp;
        logic reEnable;
        logic [11:0] location;
    } gsr_gauge_t;

    // Supply and clock monitors
    typedef struct packed {
        logic supplyHigh;
        logic supplyLow;
        logic trimFault;
    } gsr_monitor_t;

    // Serial frame events from the shift logic
    typedef struct packed {
        logic frameStart;
        logic frameEnd;
        logic [5:0] bitCount;
        logic [15:0] cmdWord;
        logic cmdIsConfig;
    } gsr_frame_t;

    // Shift control states
    typedef enum logic [1:0] {
        GSR_IDLE = 2'b00,
        GSR_SHIFT = 2'b01,
        GSR_CLOSE = 2'b10
    } gsr_state_t;

endpackage

/* File: hdl/gsr_flag_latch.sv */
/*
 Sticky flag with set-over-clear priority, one per latched status bit except the homing bits.
 Assumes set and clear are single-clock synchronous strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module gsr_flag_latch (
    input wire logic mclk,
    input wire logic rst,
    input wire logic setIn,
    input wire logic clearIn,
    output logic flag
);
    import gsr_pkg::*;

    // Set wins so an event in the clear cycle is not lost
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (setIn) begin
            flag <= 1'b1;
        end else if (clearIn) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/gsr_status_readout.sv */
/*
 Status word selection, assembly and shift-out for a dual gauge driver.
 Assumes the serial front end delivers frame start and end strobes,
 bit counts and command words on mclk, and that motion, homing
 integrator and monitor units present their state on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module gsr_status_readout #(
    parameter int WORD_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire gsr_pkg::gsr_frame_t frame,
    input wire logic shiftStrobe,
    input wire gsr_pkg::gsr_gauge_t gauge0,
    input wire gsr_pkg::gsr_gauge_t gauge1,
    input wire gsr_pkg::gsr_monitor_t monitor,
    input wire logic integratorValid,
    input wire logic [14:0] integratorValue,
    output logic serialOut,
    output logic serialOutEn_n,
    output logic driverDisable,
    output logic [1:0] gaugeDisable
);
    import gsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Frame qualification and selection

    logic validFrame;
    logic [3:0] select_reg;
    logic [3:0] sentSelect_reg;
    gsr_state_t state_reg;
    gsr_state_t state_next;
    logic [WORD_W-1:0] shift_reg;

    // Length must be non-zero and a whole number of words
    assign validFrame = frame.frameEnd && (frame.bitCount != 6'h00) &&
        (frame.bitCount[3:0] == 4'h0);

    // Select field only moves on a valid config write
    always_ff @(posedge mclk) begin
        if (rst) begin
            select_reg <= GSR_SEL_DEVICE;
        end else if (validFrame && frame.cmdIsConfig) begin
            select_reg <= frame.cmdWord[GSR_CMD_SEL_HI:GSR_CMD_SEL_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched fault and event flags

    logic ovFlag;
    logic uvFlag;
    logic anyFlag;
    logic [1:0] movFlag;
    logic [1:0] otFlag;
    logic [1:0] homFlag;
    logic [1:0] zeroSeen_reg;
    logic [11:0] lastLoc0_reg;
    logic [11:0] lastLoc1_reg;
    logic faultClear;
    logic msgEnd;
    logic [1:0] locMoved;

    // Supply faults clear only after the device word went out in a valid frame
    assign faultClear = validFrame && (sentSelect_reg[GSR_SEL_TOP] == 1'b0);
    assign msgEnd = validFrame;
    assign locMoved[0] = gauge0.location != lastLoc0_reg;
    assign locMoved[1] = gauge1.location != lastLoc1_reg;

    gsr_flag_latch uOv (
        .mclk(mclk),
        .rst(rst),
        .setIn(monitor.supplyHigh),
        .clearIn(faultClear),
        .flag(ovFlag)
    );

    gsr_flag_latch uUv (
        .mclk(mclk),
        .rst(rst),
        .setIn(monitor.supplyLow),
        .clearIn(faultClear),
        .flag(uvFlag)
    );

    gsr_flag_latch uAny (
        .mclk(mclk),
        .rst(rst),
        .setIn(monitor.supplyHigh | monitor.supplyLow),
        .clearIn(faultClear),
        .flag(anyFlag)
    );

    // Per-gauge motion, homing and thermal flags
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gGauge
            gsr_gauge_t gs;
            assign gs = (g == 0) ? gauge0 : gauge1;

            gsr_flag_latch uMov (
                .mclk(mclk),
                .rst(rst),
                .setIn(locMoved[g]),
                .clearIn(msgEnd),
                .flag(movFlag[g])
            );

            // Thermal flag holds until the gauge is re-enabled
            gsr_flag_latch uOt (
                .mclk(mclk),
                .rst(rst),
                .setIn(gs.overTemp),
                .clearIn(gs.reEnable),
                .flag(otFlag[g])
            );

            // Zero seen, then the next message ends homing
            always_ff @(posedge mclk) begin
                if (rst) begin
                    homFlag[g] <= 1'b0;
                    zeroSeen_reg[g] <= 1'b0;
                end else if (gs.homingReq) begin
                    homFlag[g] <= 1'b1;
                    zeroSeen_reg[g] <= 1'b0;
                end else if (gs.homingOff) begin
                    homFlag[g] <= 1'b0;
                    zeroSeen_reg[g] <= 1'b0;
                end else if (zeroSeen_reg[g] && msgEnd) begin
                    homFlag[g] <= 1'b0;
                    zeroSeen_reg[g] <= 1'b0;
                end else if (gs.zeroFound && homFlag[g]) begin
                    zeroSeen_reg[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // Reference location for motion detection, rebased per message
    always_ff @(posedge mclk) begin
        if (rst) begin
            lastLoc0_reg <= GSR_POS_RESET;
            lastLoc1_reg <= GSR_POS_RESET;
        end else if (msgEnd) begin
            lastLoc0_reg <= gauge0.location;
            lastLoc1_reg <= gauge1.location;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Homing integrator capture

    logic [GSR_ACC_W-1:0] acc_reg;

    // Last result stays once homing stops; only reset zeroes it
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_reg <= GSR_ACC_RESET;
        end else if (integratorValid) begin
            acc_reg <= integratorValue;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word assembly

    logic [WORD_W-1:0] devWord;
    logic [WORD_W-1:0] accWord;
    logic [WORD_W-1:0] posWord;
    logic [WORD_W-1:0] selWord;

    // Device status word
    assign devWord = {
        gauge1.heading, gauge0.heading,
        gauge1.zeroEnd, gauge0.zeroEnd,
        gauge1.offTarget, gauge0.offTarget,
        ovFlag, uvFlag,
        monitor.trimFault,
        anyFlag,
        movFlag[1], movFlag[0],
        homFlag[1], homFlag[0],
        otFlag[1], otFlag[0]
    };

    // Integrator word, sign of value sits just under the homing bit
    assign accWord = {homFlag[0], acc_reg};

    // Location read live; the load at chip select fall freezes it
    assign posWord = {gauge0.enabled, gauge0.heading,
        gauge0.headingVsTarget, gauge0.offTarget, gauge0.location};

    // Select decode; codes 9 to 11 also give the integrator word, other unused codes the device word
    always_comb begin
        if (select_reg[GSR_SEL_TOP] == 1'b0) begin
            selWord = devWord;
        end else if (select_reg[GSR_SEL_NEXT] == 1'b0) begin
            selWord = accWord;
        end else if (select_reg == GSR_SEL_POS0) begin
            selWord = posWord;
        end else begin
            selWord = devWord;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift control

    // Next state from frame strobes
    always_comb begin
        case (state_reg)
            GSR_IDLE: begin
                state_next = frame.frameStart ? GSR_SHIFT : GSR_IDLE;
            end
            GSR_SHIFT: begin
                state_next = frame.frameEnd ? GSR_CLOSE : GSR_SHIFT;
            end
            GSR_CLOSE: begin
                state_next = GSR_IDLE;
            end
            default: begin
                state_next = GSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= GSR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Load at chip select fall, then MSB first, refilling from input
    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_reg <= '0;
            sentSelect_reg <= GSR_SEL_DEVICE;
        end else if (frame.frameStart) begin
            shift_reg <= selWord;
            sentSelect_reg <= select_reg;
        end else if (state_reg == GSR_SHIFT && shiftStrobe) begin
            shift_reg <= {shift_reg[WORD_W-2:0], frame.cmdWord[0]};
        end
    end

    // Pin driven from registers only; released between frames
    always_ff @(posedge mclk) begin
        if (rst) begin
            serialOut <= 1'b0;
            serialOutEn_n <= 1'b1;
        end else begin
            serialOut <= frame.frameStart ? selWord[WORD_W-1] :
                (shiftStrobe ? shift_reg[WORD_W-2] : serialOut);
            serialOutEn_n <= !(state_next == GSR_SHIFT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Driver shutdowns

    // Overvoltage stops all coils; thermal stops the one gauge
    always_ff @(posedge mclk) begin
        if (rst) begin
            driverDisable <= 1'b0;
            gaugeDisable <= 2'b00;
        end else begin
            driverDisable <= ovFlag | monitor.supplyHigh;
            gaugeDisable <= otFlag |
                {gauge1.overTemp, gauge0.overTemp};
        end
    end
endmodule
`default_nettype wire

/* File: test/gsr_status_readout_assertions.sv */
/*
 Port checker for the status readout.
 Assumes one mclk domain and a synchronous active-high rst.
*/
`timescale 1ns/1ps
`default_nettype none
module gsr_status_readout_assertions #(
    parameter int WORD_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire gsr_pkg::gsr_frame_t frame,
    input wire logic shiftStrobe,
    input wire gsr_pkg::gsr_gauge_t gauge0,
    input wire gsr_pkg::gsr_gauge_t gauge1,
    input wire gsr_pkg::gsr_monitor_t monitor,
    input wire logic integratorValid,
    input wire logic [14:0] integratorValue,
    input wire logic serialOut,
    input wire logic serialOutEn_n,
    input wire logic driverDisable,
    input wire logic [1:0] gaugeDisable
);
    import gsr_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Pin driven only between start and end
    sequence s_open;
        frame.frameStart;
    endsequence
    sequence s_driven;
        !serialOutEn_n;
    endsequence
    property p_drive;
        s_open |=> s_driven;
    endproperty
    a_drive: assert property (p_drive)
        else $error("pin not driven");
    property p_idle;
        !frame.frameStart && serialOutEn_n |=> serialOutEn_n;
    endproperty
    a_idle: assert property (p_idle)
        else $error("pin driven when idle");
    property p_release;
        frame.frameEnd |-> ##[1:2] serialOutEn_n;
    endproperty
    a_release: assert property (p_release)
        else $error("pin not released");
    // One or two edges of latency accepted
    property p_ov_off;
        monitor.supplyHigh |-> ##[1:2] driverDisable;
    endproperty
    a_ov_off: assert property (p_ov_off)
        else $error("drivers left on");
    property p_uv_on;
        $rose(driverDisable) |->
            $past(monitor.supplyHigh) || $past(monitor.supplyHigh, 2);
    endproperty
    a_uv_on: assert property (p_uv_on)
        else $error("drivers off without cause");
    property p_ot0;
        gauge0.overTemp |-> ##[1:2] gaugeDisable[0];
    endproperty
    a_ot0: assert property (p_ot0)
        else $error("gauge 0 not shut down");
    property p_ot1;
        gauge1.overTemp |-> ##[1:2] gaugeDisable[1];
    endproperty
    a_ot1: assert property (p_ot1)
        else $error("gauge 1 not shut down");
    property p_hold0;
        $fell(gaugeDisable[0]) |->
            $past(gauge0.reEnable) || $past(gauge0.reEnable, 2);
    endproperty
    a_hold0: assert property (p_hold0)
        else $error("shutdown ended early");
endmodule
bind gsr_status_readout gsr_status_readout_assertions #(.WORD_W(WORD_W))
    chk_inst (.mclk, .rst, .frame, .shiftStrobe, .gauge0, .gauge1,
    .monitor, .integratorValid, .integratorValue, .serialOut,
    .serialOutEn_n, .driverDisable, .gaugeDisable);
`default_nettype wire

/* File: test/gsr_spi_master.sv */
/*
 Master model: frames, bit strobes and capture of the output bit.
 Assumes xfer is called only after reset is released.
*/
`timescale 1ns/1ps
`default_nettype none
module gsr_spi_master (
    input wire logic mclk,
    input wire logic serialOut,
    output var gsr_pkg::gsr_frame_t frame,
    output var logic shiftStrobe
);
    import gsr_pkg::*;
    logic slow;
    initial begin
        frame = '0;
        shiftStrobe = 1'h0;
        slow = 1'h0;
    end
    ////////////////////////////////////////
    // Bits sampled late, clear of either latency
    task automatic xfer(input logic cfg, input logic [15:0] cmd,
            input logic [5:0] len, output logic [15:0] got);
        @(posedge mclk);
        frame.frameStart <= 1'h1;
        frame.cmdWord <= cmd;
        frame.cmdIsConfig <= cfg;
        frame.bitCount <= len;
        @(posedge mclk);
        frame.frameStart <= 1'h0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge mclk);
            if (slow)
                @(posedge mclk);
            @(negedge mclk);
            got[i] = serialOut;
            @(posedge mclk);
            shiftStrobe <= 1'h1;
            @(posedge mclk);
            shiftStrobe <= 1'h0;
        end
        @(posedge mclk);
        frame.frameEnd <= 1'h1;
        @(posedge mclk);
        frame.frameEnd <= 1'h0;
        // Released command carries junk
        frame.cmdWord <= ~cmd;
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
/*
 Self-checking bench with a reference model of the status words.
 Assumes the package, the design, its checker and the master model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gsr_pkg::*;
    localparam int HREQ = 16;
    localparam int HOFF = 15;
    localparam int ZFND = 14;
    localparam int OTMP = 13;
    localparam int RENA = 12;
    logic mclk, rst, shiftStrobe, serialOut, serialOutEn_n;
    logic integratorValid, driverDisable, ov, uv;
    gsr_frame_t frame;
    gsr_gauge_t g [2];
    gsr_monitor_t mon;
    logic [14:0] integratorValue, acc;
    logic [1:0] gaugeDisable, mv, hm, ot;
    logic [3:0] sel;
    logic [15:0] got;
    int fails, check_count, cyc, seed;
    gsr_status_readout #(.WORD_W(GSR_WORD_W)) gsr_status_readout_inst (
        .mclk, .rst, .frame, .shiftStrobe, .gauge0(g[0]), .gauge1(g[1]),
        .monitor(mon), .integratorValid, .integratorValue, .serialOut,
        .serialOutEn_n, .driverDisable, .gaugeDisable);
    gsr_spi_master gsr_spi_master_inst (.mclk, .serialOut, .frame,
        .shiftStrobe);
    ////////////////////////////////////////
    // Clock and hang guard, run needs about 1400 cycles
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("ERROR %0t timeout", $time);
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] a, input logic [15:0] b);
        check_count++;
        if (a !== b) begin
            fails++;
            $display("ERROR %0t got %h want %h", $time, a, b);
        end
    endtask
    task automatic pulse(input int i, input int b);
        @(posedge mclk);
        g[i][b] <= 1'h1;
        @(posedge mclk);
        g[i][b] <= 1'h0;
    endtask
    // Model words
    function automatic logic [15:0] dev();
        return {g[1].heading, g[0].heading, g[1].zeroEnd, g[0].zeroEnd,
            g[1].offTarget, g[0].offTarget, ov, uv, mon.trimFault,
            ov | uv, mv, hm, ot};
    endfunction
    function automatic logic [15:0] want();
        if (!sel[3])
            return dev();
        if (!sel[2])
            return {hm[0], acc};
        if (sel == GSR_SEL_POS0)
            return {g[0].enabled, g[0].heading, g[0].headingVsTarget,
                g[0].offTarget, g[0].location};
        return dev();
    endfunction
    // One frame; valid length is nonzero and a multiple of 16
    task automatic rd(input logic cfg, input logic [15:0] cmd,
            input logic [5:0] len);
        logic [15:0] exp;
        logic dw;
        exp = want();
        dw = !sel[3] || (sel[2] && sel != GSR_SEL_POS0);
        gsr_spi_master_inst.xfer(cfg, cmd, len, got);
        chk(got, exp);
        if (len != 6'h0 && len[3:0] == 4'h0) begin
            if (cfg)
                sel = cmd[11:8];
            mv = 2'h0;
            if (dw)
                {ov, uv} = 2'h0;
        end
    endtask
    initial begin
        seed = 21;
        rst = 1'h1;
        mon = '0;
        mon.trimFault = 1'h1;
        integratorValid = 1'h0;
        integratorValue = 15'h0;
        sel = GSR_SEL_DEVICE;
        {mv, hm, ot, ov, uv} = 8'h0;
        acc = 15'h0;
        for (int i = 0; i < 2; i++) begin
            g[i] = '0;
            g[i][21:17] = 5'($random(seed));
        end
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        @(negedge mclk);
        chk({12'h0, gaugeDisable, driverDisable, serialOutEn_n}, 16'h1);
        rd(1'h0, 16'h0, 6'h10);
        @(posedge mclk);
        g[0].location <= 12'($random(seed)) | 12'h1;
        g[1].location <= 12'($random(seed)) | 12'h1;
        mv = 2'h3;
        rd(1'h1, 16'h0b00, 6'h10);
        rd(1'h0, 16'h0, 6'h10);
        @(posedge mclk);
        integratorValue <= 15'($random(seed));
        integratorValid <= 1'h1;
        @(posedge mclk);
        integratorValid <= 1'h0;
        acc = integratorValue;
        integratorValue <= ~integratorValue;
        rd(1'h0, 16'h0, 6'h10);
        pulse(0, HREQ);
        hm[0] = 1'h1;
        rd(1'h0, 16'h0, 6'h10);
        pulse(0, HOFF);
        hm[0] = 1'h0;
        // Zero found: bit stays through this message, then drops
        pulse(0, HREQ);
        pulse(0, ZFND);
        hm[0] = 1'h1;
        rd(1'h0, 16'h0, 6'h10);
        hm[0] = 1'h0;
        rd(1'h1, 16'h0c00, 6'h10);
        gsr_spi_master_inst.slow = 1'h1;
        fork
            rd(1'h0, 16'h0, 6'h10);
            begin
                repeat (3) @(posedge mclk);
                repeat (4) @(posedge mclk) g[0].location <= ~g[0].location;
            end
        join
        gsr_spi_master_inst.slow = 1'h0;
        rd(1'h1, 16'h0500, 6'h08);
        rd(1'h1, 16'h0500, 6'h20);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            mon.supplyLow <= (k == 0);
            mon.supplyHigh <= (k == 1);
            @(posedge mclk);
            mon.supplyLow <= 1'h0;
            mon.supplyHigh <= 1'h0;
            {ov, uv} = (k == 0) ? 2'h1 : 2'h2;
            @(negedge mclk);
            chk({15'h0, driverDisable}, {15'h0, k == 1});
            rd(1'h0, 16'h0, 6'h08);
            rd(1'h0, 16'h0, 6'h10);
            rd(1'h0, 16'h0, 6'h10);
        end
        for (int i = 0; i < 2; i++) begin
            pulse(i, OTMP);
            ot[i] = 1'h1;
            rd(1'h0, 16'h0, 6'h10);
            rd(1'h0, 16'h0, 6'h10);
            pulse(i, RENA);
            ot[i] = 1'h0;
            pulse(i, HREQ);
            hm[i] = 1'h1;
            rd(1'h0, 16'h0, 6'h10);
            pulse(i, HOFF);
            hm[i] = 1'h0;
        end
        // Mid-run reset with the integrator word selected
        rd(1'h1, 16'h0800, 6'h10);
        @(posedge mclk);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        sel = GSR_SEL_DEVICE;
        {hm, ot, ov, uv} = 6'h0;
        acc = 15'h0;
        // Reference location restarts at zero, so both gauges read moved
        mv = 2'h3;
        rd(1'h1, 16'h0800, 6'h10);
        rd(1'h0, 16'h0, 6'h10);
        finish_test();
    end
endmodule
`default_nettype wire
